/* File: sdcr_defines.svh */
// constants for conversion timing and result readout
`ifndef SDCR_DEFINES_SVH
`define SDCR_DEFINES_SVH

`define SDCR_REF_CLK_MHZ      25
`define SDCR_T_BUSY_NS        15
`define SDCR_T_OUT_NS         10
`define SDCR_T_CONV_OS1_NS    1290
`define SDCR_T_CONV_OS2_NS    3290
`define SDCR_T_CONV_OS4_NS    7250
`define SDCR_T_CONV_OS8_NS    15180
`define SDCR_T_CONV_OS16_NS   31050
`define SDCR_T_CONV_OS32_NS   62770
`define SDCR_T_CONV_OS64_NS   126200
`define SDCR_NUM_CHANNELS     8
`define SDCR_WORD_BITS        16
`define SDCR_FIRST_WORD_BITS  6'h10
`define SDCR_RATIO_RESET      3'h0
`define SDCR_PINS_RESET       9'h058

`endif

/* File: sdcr_host_model.sv */
// host controller model for the conversion and readout pins
`timescale 1ns/1ps
`default_nettype none
`include "sdcr_defines.svh"

module sdcr_host_model (
  // clock, reset, device outputs
  input  wire logic           i_ref_clk,
  input  wire logic           i_reset_n,
  input  wire logic           i_busy,
  input  wire logic           i_serial_a,
  input  wire logic           i_serial_b,
  // pins toward the device
  output var sdcr_pkg::sdcr_pins_s o_pins,
  output var logic            o_serial_clk
);
  localparam int START_GAP = 313;
  localparam int WAKE_GAP  = 2500;
  int cyc;
  int last_start;
  int last_wake;

  initial
  begin
    o_pins       = `SDCR_PINS_RESET;
    o_serial_clk = 1'b0;
    last_start   = -START_GAP;
    last_wake    = 0;
  end

  // cycles since reset release
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end

  // both high starts a conversion
  task automatic set_conv(input logic a, input logic b);
    while (a && b && (cyc - last_wake < WAKE_GAP || cyc - last_start < START_GAP))
      @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_pins.conv_a = a;
    o_pins.conv_b = b;
    if (a && b)
      last_start = cyc;
  endtask

  // ratio changes only while idle
  task automatic set_ratio(input logic [2:0] r);
    for (int n = 0; n < 4000 && i_busy; n++)
      @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_pins.ratio = r;
  endtask

  // leaving standby restarts the wake-up wait
  task automatic set_standby(input logic s);
    @(negedge i_ref_clk);
    o_pins.standby_n = s;
    if (s)
      last_wake = cyc;
  endtask

  task automatic set_read(input logic serial, input logic cs_n, input logic rd_n);
    @(negedge i_ref_clk);
    o_pins.serial_mode = serial;
    o_pins.cs_n        = cs_n;
    o_pins.rd_n        = rd_n;
  endtask

  // one serial clock period, lines taken at the falling edge
  task automatic ser_bit(output logic a, output logic b);
    o_serial_clk = 1'b1;
    #7.5;
    o_serial_clk = 1'b0;
    a = i_serial_a;
    b = i_serial_b;
    #7.5;
  endtask
endmodule // sdcr_host_model
`default_nettype wire

/* File: sdcr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module sdcr_pin_sync #(
  parameter int             W         = 1,
  parameter logic [W-1:0]   RESET_VAL = '0
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_clk_en,
  // pins in, filtered levels out
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_filt
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] filt_next;

  // a bit follows once the second and third stages agree
  assign filt_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & o_filt);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      o_filt <= RESET_VAL;
    end
    else if (i_clk_en)
    begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_filt <= filt_next;
    end
  end

endmodule // sdcr_pin_sync

`default_nettype wire

/* File: sdcr_pkg.sv */
// types for conversion timing and result readout
`default_nettype none

package sdcr_pkg;

  typedef enum logic [0:0] {
    SDCR_IDLE,
    SDCR_CONV
  } sdcr_state_e;

  typedef struct packed {
    logic       conv_a;
    logic       conv_b;
    logic       standby_n;
    logic       serial_mode;
    logic       cs_n;
    logic       rd_n;
    logic [2:0] ratio;
  } sdcr_pins_s;

  typedef logic [7:0][15:0] sdcr_sample_t;
  typedef logic [15:0]      sdcr_word_t;

endpackage

`default_nettype wire

/* File: sdcr_top.sv */
// conversion timing, parallel and serial result readout
`timescale 1ns/1ps
`default_nettype none
`include "sdcr_defines.svh"

// What this block does
// - busy stays high for the conversion time set by the ratio.
// - busy rises shortly after the later of both start rising edges.
// - tied strobes falling drive the parallel bus out of high impedance.
// - tied strobes rising release the parallel bus.
// - tied strobes falling drive the first-word flag high or low.
// - each separate read strobe fall presents the next word.
// - separate chip select fall drives the first-word flag low.
// - each separate read strobe fall updates the first-word flag.
// - chip select rise releases the first-word flag.
// - separate chip select rise releases the parallel bus.
// - serial chip select fall enables both serial output lines.
// - each serial clock rising edge shifts a new bit out per line.
// - serial chip select rise releases both serial output lines.
// - serial chip select fall drives the first-word flag.
// - first-word flag falls after the sixteenth serial clock falling edge.

module sdcr_top (
  // clocks, reset, enable
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_serial_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  // conversion control pins
  input  wire logic                  i_conv_start_a,
  input  wire logic                  i_conv_start_b,
  input  wire logic                  i_standby_n,
  input  wire logic [2:0]            i_ratio_select,
  input  wire logic                  i_serial_mode,
  // converter core samples
  input  wire sdcr_pkg::sdcr_sample_t i_channel_data,
  // read strobes
  input  wire logic                  i_cs_n,
  input  wire logic                  i_rd_n,
  // conversion status
  output logic                       o_busy,
  // parallel read port
  output sdcr_pkg::sdcr_word_t       o_parallel_bus,
  output logic                       o_parallel_bus_oe,
  output logic                       o_first_word_flag,
  output logic                       o_first_word_flag_oe,
  // serial read port
  output logic                       o_serial_out_a,
  output logic                       o_serial_out_b,
  output logic                       o_serial_out_oe
);

  localparam int BUSY_RAW  = (`SDCR_T_BUSY_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int BUSY_CYC  = (BUSY_RAW > 0) ? BUSY_RAW : 1;
  localparam int OUT_RAW   = (`SDCR_T_OUT_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int OUT_CYC   = (OUT_RAW > 0) ? OUT_RAW : 1;
  localparam int CONV_OS1  = (`SDCR_T_CONV_OS1_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS2  = (`SDCR_T_CONV_OS2_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS4  = (`SDCR_T_CONV_OS4_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS8  = (`SDCR_T_CONV_OS8_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS16 = (`SDCR_T_CONV_OS16_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS32 = (`SDCR_T_CONV_OS32_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int CONV_OS64 = (`SDCR_T_CONV_OS64_NS * `SDCR_REF_CLK_MHZ) / 1000;
  localparam int WORD_W    = $clog2(`SDCR_NUM_CHANNELS);

  // busy length in reference clocks for each ratio code
  function automatic logic [11:0] conv_cycles(input logic [2:0] r);
    logic [11:0] c;
    c = CONV_OS1[11:0];
    case (r)
      3'h1:    c = CONV_OS2[11:0];
      3'h2:    c = CONV_OS4[11:0];
      3'h3:    c = CONV_OS8[11:0];
      3'h4:    c = CONV_OS16[11:0];
      3'h5:    c = CONV_OS32[11:0];
      3'h6:    c = CONV_OS64[11:0];
      default: c = CONV_OS1[11:0];
    endcase
    return c;
  endfunction

  // pin synchronisation
  sdcr_pkg::sdcr_pins_s pin_raw;
  sdcr_pkg::sdcr_pins_s pin;
  sdcr_pkg::sdcr_pins_s pin_prev_reg;

  assign pin_raw.conv_a      = i_conv_start_a;
  assign pin_raw.conv_b      = i_conv_start_b;
  assign pin_raw.standby_n   = i_standby_n;
  assign pin_raw.serial_mode = i_serial_mode;
  assign pin_raw.cs_n        = i_cs_n;
  assign pin_raw.rd_n        = i_rd_n;
  assign pin_raw.ratio       = i_ratio_select;

  sdcr_pin_sync #(
    .W         ($bits(sdcr_pkg::sdcr_pins_s)),
    .RESET_VAL (`SDCR_PINS_RESET)
  ) u_pin_sync (
    .i_clk     (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   (pin_raw),
    .o_filt    (pin)
  );

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pin_prev_reg <= `SDCR_PINS_RESET;
    else if (i_clk_en)
      pin_prev_reg <= pin;
  end

  // edge events
  sdcr_pkg::sdcr_state_e state_reg;
  logic                  start_evt;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  rd_fall;

  assign start_evt = pin.conv_a && pin.conv_b && !(pin_prev_reg.conv_a && pin_prev_reg.conv_b)
                     && pin.standby_n && (state_reg == sdcr_pkg::SDCR_IDLE);
  assign cs_fall   = pin_prev_reg.cs_n && !pin.cs_n;
  assign cs_rise   = !pin_prev_reg.cs_n && pin.cs_n;
  assign rd_fall   = pin_prev_reg.rd_n && !pin.rd_n && !pin.cs_n && !pin.serial_mode;

  // conversion sequencing
  logic [11:0]            conv_cnt_reg;
  logic [2:0]             ratio_reg;
  logic                   busy_reg;
  logic [BUSY_CYC-1:0]    start_dly_reg;
  sdcr_pkg::sdcr_sample_t sample_reg;
  sdcr_pkg::sdcr_sample_t results_reg;

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      start_dly_reg <= '0;
    else if (i_clk_en)
      start_dly_reg <= BUSY_CYC'({start_dly_reg, start_evt});
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg    <= sdcr_pkg::SDCR_IDLE;
      conv_cnt_reg <= '0;
      busy_reg     <= 1'b0;
    end
    else if (i_clk_en)
    begin
      unique case (state_reg)
        sdcr_pkg::SDCR_IDLE:
        begin
          if (start_evt)
            state_reg <= sdcr_pkg::SDCR_CONV;
        end
        sdcr_pkg::SDCR_CONV:
        begin
          if (start_dly_reg[BUSY_CYC-1])
          begin
            busy_reg     <= 1'b1;
            conv_cnt_reg <= conv_cycles(ratio_reg) - 12'h001;
          end
          else if (busy_reg && conv_cnt_reg != 12'h000)
            conv_cnt_reg <= conv_cnt_reg - 12'h001;
          else if (busy_reg)
          begin
            busy_reg  <= 1'b0;
            state_reg <= sdcr_pkg::SDCR_IDLE;
          end
        end
      endcase
    end
  end

  logic conv_done;
  assign conv_done = busy_reg && conv_cnt_reg == 12'h000 && !start_dly_reg[BUSY_CYC-1];

  // sample at start, publish and take the next ratio at busy fall
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      sample_reg  <= '0;
      results_reg <= '0;
      ratio_reg   <= `SDCR_RATIO_RESET;
    end
    else if (i_clk_en)
    begin
      if (start_evt)
        sample_reg <= i_channel_data;
      if (conv_done)
      begin
        results_reg <= sample_reg;
        ratio_reg   <= pin.ratio;
      end
    end
  end

  // parallel readout
  logic [WORD_W-1:0]    word_idx_reg;
  sdcr_pkg::sdcr_word_t rd_word;
  sdcr_pkg::sdcr_word_t bus_reg;
  logic                 bus_oe_reg;
  logic                 flag_reg;
  logic                 flag_oe_reg;
  logic                 ser_oe_reg;
  logic                 done_s1_reg;
  logic                 done_s2_reg;

  assign rd_word = results_reg[word_idx_reg];

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      word_idx_reg <= '0;
      bus_reg      <= '0;
      bus_oe_reg   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (cs_fall && !pin.serial_mode)
        bus_oe_reg <= 1'b1;
      else if (cs_rise)
        bus_oe_reg <= 1'b0;
      if (conv_done)
        word_idx_reg <= '0;
      else if (rd_fall)
      begin
        bus_reg      <= rd_word;
        word_idx_reg <= word_idx_reg + 1'b1;
      end
    end
  end

  // first-word flag for both read modes
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flag_reg    <= 1'b0;
      flag_oe_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (cs_rise)
        flag_oe_reg <= 1'b0;
      else if (cs_fall)
        flag_oe_reg <= 1'b1;
      if (rd_fall)
        flag_reg <= (word_idx_reg == '0);
      else if (cs_fall)
        flag_reg <= pin.serial_mode;
      else if (pin.serial_mode && !pin.cs_n && done_s2_reg)
        flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      ser_oe_reg <= 1'b0;
    else if (i_clk_en)
    begin
      if (cs_fall && pin.serial_mode)
        ser_oe_reg <= 1'b1;
      else if (cs_rise)
        ser_oe_reg <= 1'b0;
    end
  end

  // serial clock domain; chip select high clears it between frames
  logic       ser_clr;
  logic [5:0] bit_cnt_reg;
  logic       ser_a_reg;
  logic       ser_b_reg;
  logic       done16_reg;
  logic       ser_bit_a;
  logic       ser_bit_b;

  assign ser_clr   = i_cs_n || !i_reset_n;
  assign ser_bit_a = results_reg[{1'b0, bit_cnt_reg[5:4]}][4'hf - bit_cnt_reg[3:0]];
  assign ser_bit_b = results_reg[{1'b1, bit_cnt_reg[5:4]}][4'hf - bit_cnt_reg[3:0]];

  always_ff @(posedge i_serial_clk or posedge ser_clr)
  begin
    if (ser_clr)
    begin
      bit_cnt_reg <= '0;
      ser_a_reg   <= 1'b0;
      ser_b_reg   <= 1'b0;
    end
    else
    begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
      ser_a_reg   <= ser_bit_a;
      ser_b_reg   <= ser_bit_b;
    end
  end

  always_ff @(negedge i_serial_clk or posedge ser_clr)
  begin
    if (ser_clr)
      done16_reg <= 1'b0;
    else if (bit_cnt_reg == `SDCR_FIRST_WORD_BITS)
      done16_reg <= 1'b1;
  end

  // first word done, back to the reference domain
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      done_s1_reg <= done16_reg;
      done_s2_reg <= done_s1_reg;
    end
  end

  // outputs
  assign o_busy               = busy_reg;
  assign o_parallel_bus       = bus_reg;
  assign o_parallel_bus_oe    = bus_oe_reg;
  assign o_first_word_flag    = flag_reg;
  assign o_first_word_flag_oe = flag_oe_reg;
  assign o_serial_out_a       = ser_a_reg;
  assign o_serial_out_b       = ser_b_reg;
  assign o_serial_out_oe      = ser_oe_reg;

  // busy length helper
  logic [11:0] busy_len_reg;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      busy_len_reg <= '0;
    else if (i_clk_en)
      busy_len_reg <= busy_reg ? busy_len_reg + 12'h001 : 12'h000;
  end

  a_busy_rise: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    start_evt && i_clk_en |-> ##[1:BUSY_CYC] start_dly_reg[BUSY_CYC-1] ##1 busy_reg)
    else $error("busy did not rise after start");
  a_busy_len: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && conv_done |=> busy_len_reg == conv_cycles($past(ratio_reg)))
    else $error("busy length wrong for ratio");
  a_bus_drive: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && cs_fall && !pin.serial_mode |-> ##OUT_CYC o_parallel_bus_oe)
    else $error("parallel bus not driven after select");
  a_bus_release: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && cs_rise |-> ##OUT_CYC !o_parallel_bus_oe && !o_first_word_flag_oe)
    else $error("outputs not released after select rise");
  a_word_next: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && rd_fall |=> o_parallel_bus == $past(rd_word)
    && word_idx_reg == $past(word_idx_reg) + 1'b1)
    else $error("read strobe did not present next word");
  a_flag_first: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && rd_fall |=> o_first_word_flag_oe && o_first_word_flag == ($past(word_idx_reg) == '0))
    else $error("first-word flag wrong after read strobe");
  a_flag_select: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && cs_fall && !rd_fall |=> o_first_word_flag_oe && o_first_word_flag == $past(pin.serial_mode))
    else $error("first-word flag wrong after select fall");
  a_serial_enable: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && pin.serial_mode && (cs_fall || cs_rise) |=> o_serial_out_oe == $past(cs_fall))
    else $error("serial enable does not follow select");
  a_flag_drop: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && pin.serial_mode && !pin.cs_n && !cs_fall && done_s2_reg |=> !o_first_word_flag)
    else $error("first-word flag still high after first word");
  a_serial_shift: assert property (@(posedge i_serial_clk) disable iff (ser_clr)
    1'b1 |=> o_serial_out_a == $past(ser_bit_a) && bit_cnt_reg == $past(bit_cnt_reg) + 6'h01)
    else $error("serial line did not shift");

endmodule // sdcr_top

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for conversion timing and result readout
`timescale 1ns/1ps
`default_nettype none
`include "sdcr_defines.svh"

module testbench;
  localparam int CONV_NS [8] = '{`SDCR_T_CONV_OS1_NS, `SDCR_T_CONV_OS2_NS,
    `SDCR_T_CONV_OS4_NS, `SDCR_T_CONV_OS8_NS, `SDCR_T_CONV_OS16_NS,
    `SDCR_T_CONV_OS32_NS, `SDCR_T_CONV_OS64_NS, `SDCR_T_CONV_OS1_NS};
  logic                   ref_clk;
  logic                   reset_n;
  logic                   serial_clk;
  sdcr_pkg::sdcr_sample_t chan_data;
  sdcr_pkg::sdcr_pins_s   pins;
  sdcr_pkg::sdcr_word_t   pbus;
  logic                   busy;
  logic                   pbus_oe;
  logic                   flag;
  logic                   flag_oe;
  logic                   sout_a;
  logic                   sout_b;
  logic                   sout_oe;
  wire logic              line_a;
  wire logic              line_b;
  int                     bad_count;
  int                     cmp_count;
  int                     cur_ratio;
  int                     batch;

  // released lines show the inverse of their last level
  assign line_a = sout_oe ? sout_a : ~sout_a;
  assign line_b = sout_oe ? sout_b : ~sout_b;

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  sdcr_top dut (
    .i_ref_clk            (ref_clk),
    .i_serial_clk         (serial_clk),
    .i_reset_n            (reset_n),
    .i_clk_en             (1'b1),
    .i_conv_start_a       (pins.conv_a),
    .i_conv_start_b       (pins.conv_b),
    .i_standby_n          (pins.standby_n),
    .i_ratio_select       (pins.ratio),
    .i_serial_mode        (pins.serial_mode),
    .i_channel_data       (chan_data),
    .i_cs_n               (pins.cs_n),
    .i_rd_n               (pins.rd_n),
    .o_busy               (busy),
    .o_parallel_bus       (pbus),
    .o_parallel_bus_oe    (pbus_oe),
    .o_first_word_flag    (flag),
    .o_first_word_flag_oe (flag_oe),
    .o_serial_out_a       (sout_a),
    .o_serial_out_b       (sout_b),
    .o_serial_out_oe      (sout_oe)
  );

  sdcr_host_model host (
    .i_ref_clk    (ref_clk),
    .i_reset_n    (reset_n),
    .i_busy       (busy),
    .i_serial_a   (line_a),
    .i_serial_b   (line_b),
    .o_pins       (pins),
    .o_serial_clk (serial_clk)
  );

  function automatic sdcr_pkg::sdcr_word_t word_of(input int c);
    return 16'(batch * 32'h2b1 + c * 32'h1357 + 32'h8001);
  endfunction

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_word(input string what, input sdcr_pkg::sdcr_word_t exp,
                          input sdcr_pkg::sdcr_word_t got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp)
    begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // bounded wait for an output level
  task automatic wait_for(input int which, input logic lvl, input int bound);
    logic v;
    for (int n = 0; n <= bound; n++)
    begin
      @(negedge ref_clk);
      case (which)
        0: v = busy;
        1: v = pbus_oe;
        3: v = sout_oe;
        default: v = flag;
      endcase
      if (v === lvl)
        return;
    end
    bad_count++;
    $display("mismatch wait %0d expected %b seen timeout", which, lvl);
    give_verdict();
  endtask

  // conversion, busy length of the ratio latched before it
  task automatic sc_convert(input int r, input int skew);
    int n;
    host.set_ratio(3'(r));
    batch++;
    for (int c = 0; c < 8; c++)
      chan_data[c] = word_of(c);
    host.set_conv(1'b1, skew == 0);
    if (skew > 0)
    begin
      repeat (skew) @(negedge ref_clk);
      chk_word("busy before later start", 16'h0, 16'(busy));
      host.set_conv(1'b1, 1'b1);
    end
    wait_for(0, 1'b1, 10);
    fork
      begin
        n = 0;
        while (busy === 1'b1 && n < 4000)
        begin
          n++;
          @(negedge ref_clk);
        end
      end
      begin
        host.set_conv(1'b0, 1'b0);
        if (cur_ratio == 6)
        begin
          repeat (400) @(negedge ref_clk);
          host.set_conv(1'b1, 1'b1);
          repeat (6) @(negedge ref_clk);
          host.set_conv(1'b0, 1'b0);
        end
      end
    join
    chk_cnt("busy cycles", CONV_NS[cur_ratio] * `SDCR_REF_CLK_MHZ / 1000, n);
    cur_ratio = r;
  endtask

  task automatic sc_par_tied;
    for (int k = 0; k < 8; k++)
    begin
      host.set_read(1'b0, 1'b0, 1'b0);
      wait_for(1, 1'b1, 10);
      chk_word("tied word", word_of(k), pbus);
      chk_word("tied flag", 16'(k == 0), 16'(flag));
      chk_word("tied flag enable", 16'h1, 16'(flag_oe));
      host.set_read(1'b0, 1'b1, 1'b1);
      wait_for(1, 1'b0, 10);
      chk_word("tied flag release", 16'h0, 16'(flag_oe));
    end
  endtask

  // starts raised in standby are refused
  task automatic sc_standby;
    host.set_standby(1'b0);
    repeat (5) @(negedge ref_clk);
    host.set_conv(1'b1, 1'b1);
    repeat (12) @(negedge ref_clk);
    chk_word("busy in standby", 16'h0, 16'(busy));
    host.set_conv(1'b0, 1'b0);
    host.set_standby(1'b1);
  endtask

  task automatic sc_par_sep;
    host.set_read(1'b0, 1'b0, 1'b1);
    wait_for(1, 1'b1, 10);
    chk_word("flag at select", 16'h0, 16'(flag));
    chk_word("flag enable at select", 16'h1, 16'(flag_oe));
    for (int k = 0; k < 8; k++)
    begin
      host.set_read(1'b0, 1'b0, 1'b0);
      repeat (6) @(negedge ref_clk);
      chk_word("separate word", word_of(k), pbus);
      chk_word("separate flag", 16'(k == 0), 16'(flag));
      host.set_read(1'b0, 1'b0, 1'b1);
      repeat (5) @(negedge ref_clk);
    end
    host.set_read(1'b0, 1'b1, 1'b1);
    wait_for(1, 1'b0, 10);
    chk_word("flag release", 16'h0, 16'(flag_oe));
  endtask

  task automatic sc_serial;
    logic a;
    logic b;
    sdcr_pkg::sdcr_word_t wa;
    sdcr_pkg::sdcr_word_t wb;
    host.set_read(1'b1, 1'b0, 1'b1);
    wait_for(3, 1'b1, 10);
    chk_word("serial flag", 16'h1, 16'(flag));
    chk_word("serial flag enable", 16'h1, 16'(flag_oe));
    #3.3;
    for (int i = 0; i < 64; i++)
    begin
      if (i == 15)
      begin
        repeat (8) @(negedge ref_clk);
        chk_word("flag before word end", 16'h1, 16'(flag));
      end
      wa = word_of(i / 16);
      wb = word_of(4 + i / 16);
      host.ser_bit(a, b);
      chk_word("line a bit", 16'(wa[15 - i % 16]), 16'(a));
      chk_word("line b bit", 16'(wb[15 - i % 16]), 16'(b));
      if (i == 15)
        wait_for(4, 1'b0, 8);
    end
    host.set_read(1'b1, 1'b1, 1'b1);
    wait_for(3, 1'b0, 10);
    chk_word("serial flag release", 16'h0, 16'(flag_oe));
  endtask

  initial
  begin
    reset_n   = 1'b0;
    chan_data = '0;
    bad_count = 0;
    cmp_count = 0;
    cur_ratio = 0;
    batch     = 0;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    for (int r = 0; r < 8; r++)
      sc_convert(r, (r == 2) ? 3 : 0);
    sc_convert(0, 0);
    sc_par_tied();
    sc_standby();
    sc_convert(0, 0);
    sc_par_sep();
    sc_convert(0, 0);
    sc_serial();
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
